// ==== rtl/bridge_pkg.sv ====
// Constants and types shared by the host bridge, its discard timer and the testbench.
// How it works
// R1 - Device role only: master and target.
// R2 - Host arbitrates and configures the device.
// R3 - Master carries DMA descriptor and buffer accesses.
// R4 - DMA addresses pass to bus unchanged.
// R5 - Descriptor or transmit read error raises interrupt.
// R6 - After error, abort all DMA requests until reset; the code also resumes them once sts_clear clears the flag.
// R7 - Host software resets to recover after error.
// R8 - Soft reset bit resets the device.
// R9 - Descriptor fetch error aborts processing at once.
// R10 - Transmit read error reported with data or close.
// R11 - Receive and descriptor writes posted, never error.
// R12 - Gating logic decides host interrupt assertion.
// R13 - Target reaches config and control registers.
// R14 - Target register access selects byte order.
// R15 - Narrow reads return word, narrow writes dropped.
// R16 - Flush read data after 32768 idle clocks.
// R17 - Error status latched, cleared by writing one.
package bridge_pkg;

  // Kinds of master request made by the DMA engines.
  typedef enum logic [2:0] {
    REQ_DESC_READ  = 3'b000,
    REQ_TXDATA_RD  = 3'b001,
    REQ_RXDATA_WR  = 3'b010,
    REQ_DESC_WRITE = 3'b011,
    REQ_DESC_CLOSE = 3'b100
  } req_kind_t;

  // Target access spaces.
  typedef enum logic [1:0] {
    SPACE_CFG = 2'b00,
    SPACE_MEM = 2'b01,
    SPACE_IO  = 2'b10
  } space_t;

  // Master sequencer states.
  typedef enum logic [1:0] {
    M_IDLE = 2'b00,
    M_BUSY = 2'b01,
    M_DONE = 2'b10
  } mstate_t;

  localparam logic [3:0]  FULL_BYTES      = 4'hf;
  localparam int          DISCARD_CLOCKS  = 32768;
  localparam logic [15:0] DISCARD_LIMIT   = 16'h7fff;
  localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
  localparam logic [7:0]  WORD_ADDR_BITS  = 8'h08;

endpackage

// ==== rtl/discard_timer.sv ====
// Read-data discard timer for the target side.
module discard_timer
  import bridge_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic reset_n,
  // Control.
  input  wire logic armed,
  input  wire logic taken,
  // Result.
  output logic      flush
);

  logic [15:0] count_q;

  // Counts clocks while fetched data waits for the bus master.
  always_ff @(posedge clk) begin
    if (!reset_n || !armed || taken) begin
      count_q <= 16'h0000;
      flush   <= 1'b0;
    end else if (count_q == DISCARD_LIMIT) begin
      count_q <= 16'h0000;
      flush   <= 1'b1; // R16
    end else begin
      count_q <= count_q + 16'h0001;
      flush   <= 1'b0;
    end
  end

endmodule

// ==== rtl/host_bridge.sv ====
// Host bridge: master error handling, target register path and interrupt gating.
module host_bridge
  import bridge_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset_n,
  // DMA master requests.
  input  wire logic        dma_req,
  input  wire req_kind_t   dma_kind,
  input  wire logic [31:0] dma_addr,
  input  wire logic [31:0] dma_wdata,
  input  wire logic        dma_last,
  // Bus master side toward the host.
  output logic             bus_req,
  output logic [31:0]      bus_addr,
  output logic [31:0]      bus_wdata,
  output logic             bus_write,
  input  wire logic        bus_grant,
  input  wire logic        bus_done,
  input  wire logic        bus_error,
  input  wire logic [31:0] bus_rdata,
  // Answers to the DMA engines.
  output logic             dma_ack,
  output logic             dma_abort,
  output logic [31:0]      dma_rdata,
  output logic             desc_abort,
  output logic             txdata_err,
  output logic             close_err,
  // Soft reset and status.
  input  wire logic        soft_reset_bit,
  input  wire logic        sts_clear,
  output logic             master_bus_error_irq,
  // Target side.
  input  wire logic        tgt_req,
  input  wire space_t      tgt_space,
  input  wire logic        tgt_write,
  input  wire logic [3:0]  tgt_byte_en,
  input  wire logic [7:0]  tgt_addr,
  input  wire logic [31:0] tgt_wdata,
  input  wire logic        tgt_big_endian,
  input  wire logic        tgt_taken,
  output logic             tgt_ready,
  output logic [31:0]      tgt_rdata,
  output logic             reg_wr,
  output space_t           reg_space,
  output logic [7:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  input  wire logic [31:0] reg_rdata,
  // Interrupt gating.
  input  wire logic        irq_src,
  input  wire logic        irq_disable,
  output logic             irq_status,
  output logic             host_irq_n
);

  ////////////////////////////////////////////////////////////////////////
  // Master side.

  mstate_t   state_q;
  req_kind_t kind_q;
  logic      last_q;
  logic      live_reset_n;
  logic      flush;

  // Soft reset acts like a hardware reset on the whole bridge.
  assign live_reset_n = reset_n & ~soft_reset_bit; // R8

  // The sequencer keeps one transfer outstanding. A refused request never
  // reaches the bus, so a latched error cannot leak stray cycles to the host,
  // and the one-cycle done state keeps back-to-back requests apart.
  // Master sequencer; only ever requests, the host grants.
  always_ff @(posedge clk) begin
    if (!live_reset_n) begin
      state_q   <= M_IDLE;
      kind_q    <= REQ_DESC_READ;
      last_q    <= 1'b0;
      bus_req   <= 1'b0;
      bus_addr  <= RESET_WORD;
      bus_wdata <= RESET_WORD;
      bus_write <= 1'b0;
    end else begin
      unique case (state_q)
        M_IDLE: begin
          if (dma_req && !master_bus_error_irq) begin // R6
            state_q   <= M_BUSY;
            kind_q    <= dma_kind;
            last_q    <= dma_last;
            bus_req   <= 1'b1; // R1 R2 R3
            bus_addr  <= dma_addr; // R4
            bus_wdata <= dma_wdata;
            bus_write <= (dma_kind == REQ_RXDATA_WR) ||
                         (dma_kind == REQ_DESC_WRITE) || (dma_kind == REQ_DESC_CLOSE);
          end
        end
        M_BUSY: begin
          if (bus_grant) begin
            bus_req <= 1'b0;
          end
          if (bus_done || bus_error) begin
            state_q <= M_DONE;
            bus_req <= 1'b0;
          end
        end
        M_DONE: begin
          state_q <= M_IDLE;
        end
        default: begin
          state_q <= M_IDLE; // The unused code falls back to idle.
        end
      endcase
    end
  end

  // Answers toward the DMA engines; one-cycle pulses, except dma_abort, high while a refused request is held, and dma_rdata, which keeps the last read word.
  always_ff @(posedge clk) begin
    if (!live_reset_n) begin
      dma_ack    <= 1'b0;
      dma_abort  <= 1'b0;
      dma_rdata  <= RESET_WORD;
      desc_abort <= 1'b0;
      txdata_err <= 1'b0;
      close_err  <= 1'b0;
    end else begin
      dma_ack    <= (state_q == M_BUSY) && bus_done && !bus_error;
      dma_abort  <= (state_q == M_IDLE) && dma_req && master_bus_error_irq; // R6
      desc_abort <= (state_q == M_BUSY) && bus_error && (kind_q == REQ_DESC_READ); // R9
      txdata_err <= (state_q == M_BUSY) && bus_error && (kind_q == REQ_TXDATA_RD) &&
                    !last_q; // R10
      close_err  <= (state_q == M_BUSY) && bus_error && (kind_q == REQ_TXDATA_RD) &&
                    last_q; // R10
      if ((state_q == M_BUSY) && bus_done && !bus_write) begin
        dma_rdata <= bus_rdata;
      end
    end
  end

  // Only reads of host memory can set it; posted writes finish without a
  // reply that the bridge could blame, so their errors are ignored here.
  // Latched error flag; a new error wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (!live_reset_n) begin
      master_bus_error_irq <= 1'b0;
    end else if ((state_q == M_BUSY) && bus_error && !bus_write) begin
      master_bus_error_irq <= 1'b1; // R5 R11
    end else if (sts_clear) begin
      master_bus_error_irq <= 1'b0; // R17 R7
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Target side.

  logic        pending_q;
  logic [31:0] fetched;

  // Byte order swap for big-endian memory accesses; I/O is little only.
  function automatic logic [31:0] swap(input logic [31:0] w);
    swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  // Read data is swapped before capture so that tgt_rdata stays a plain register.
  assign fetched = (tgt_big_endian && tgt_space == SPACE_MEM) ? swap(reg_rdata) : reg_rdata;

  // Register write path: full words only, narrow writes dropped.
  always_ff @(posedge clk) begin
    if (!live_reset_n) begin
      reg_wr    <= 1'b0;
      reg_space <= SPACE_CFG;
      reg_addr  <= 8'h00;
      reg_wdata <= RESET_WORD;
    end else begin
      reg_wr    <= tgt_req && tgt_write && (tgt_byte_en == FULL_BYTES); // R15 R13
      reg_space <= tgt_space;
      reg_addr  <= tgt_addr;
      reg_wdata <= (tgt_big_endian && tgt_space == SPACE_MEM) ? swap(tgt_wdata)
                                                              : tgt_wdata; // R14
    end
  end

  // Data stays on offer until the bus master takes it or the discard timer
  // runs out, so that a stalled master cannot lock the bus.
  // Read path: whole word fetched whatever the byte enables.
  always_ff @(posedge clk) begin
    if (!live_reset_n) begin
      pending_q <= 1'b0;
      tgt_ready <= 1'b0;
      tgt_rdata <= RESET_WORD;
    end else if (tgt_req && !tgt_write) begin
      pending_q <= 1'b1;
      tgt_ready <= 1'b1;
      tgt_rdata <= fetched; // R15 R14 R13
    end else if (tgt_taken || flush) begin
      pending_q <= 1'b0; // R16
      tgt_ready <= 1'b0;
      tgt_rdata <= RESET_WORD;
    end
  end

  // The timer restarts whenever the data is taken or is no longer pending.
  discard_timer u_discard (
    .clk     (clk),
    .reset_n (live_reset_n),
    .armed   (pending_q),
    .taken   (tgt_taken),
    .flush   (flush)
  );

  ////////////////////////////////////////////////////////////////////////
  // Interrupt gating.

  // The gate is registered so that the host pin comes straight from a flip-flop.
  // Host sees the interrupt only while not disabled; status shows the raw source.
  always_ff @(posedge clk) begin
    if (!live_reset_n) begin
      host_irq_n <= 1'b1;
      irq_status <= 1'b0;
    end else begin
      host_irq_n <= ~(irq_src && !irq_disable); // R12
      irq_status <= irq_src;
    end
  end

endmodule

// ==== tb/bridge_checker.sv ====
// Port assertions for the host bridge.
module bridge_checker
  import bridge_pkg::*;
(
  // Watched ports.
  input wire logic        clk, reset_n, soft_reset_bit, sts_clear, bus_req, bus_write,
  input wire logic        bus_done, bus_error, dma_ack, desc_abort, tgt_req, tgt_write,
  input wire logic        reg_wr, irq_src, irq_disable, host_irq_n, master_bus_error_irq,
  input wire req_kind_t   dma_kind,
  input wire logic [3:0]  tgt_byte_en,
  input wire logic [31:0] dma_addr, bus_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n || soft_reset_bit);
  // A read that the host answers with an error.
  sequence s_rd_err;
    bus_req && bus_error && !bus_write;
  endsequence
  sequence s_desc_err;
    s_rd_err ##0 dma_kind == REQ_DESC_READ;
  endsequence
  a_addr_unchanged: assert property ($rose(bus_req) |-> bus_addr == $past(dma_addr))
    else $error("bus address differs from request");
  a_err_sets_flag: assert property (s_rd_err |=> master_bus_error_irq)
    else $error("read error left status low");
  a_desc_abort_now: assert property (s_desc_err |=> desc_abort)
    else $error("descriptor fetch not aborted");
  a_refuse_after_err: assert property (master_bus_error_irq |=> !$rose(bus_req))
    else $error("request issued after error");
  a_posted_no_err: assert property (
    bus_req && bus_error && bus_write && !master_bus_error_irq |=> !master_bus_error_irq)
    else $error("posted write raised status");
  a_flag_sticky: assert property (master_bus_error_irq && !sts_clear |=> master_bus_error_irq)
    else $error("status dropped by itself");
  a_ack_on_done: assert property (bus_req && bus_done && !bus_error |=> dma_ack)
    else $error("no answer after done");
  a_narrow_dropped: assert property (
    tgt_req && tgt_write && tgt_byte_en != FULL_BYTES |=> !reg_wr)
    else $error("narrow write reached registers");
  a_irq_gated: assert property (1 |=>
    host_irq_n == !($past(irq_src) && !$past(irq_disable)))
    else $error("host interrupt gating wrong");
endmodule

bind host_bridge bridge_checker u_bridge_checker (.*);

// ==== tb/host_model.sv ====
// Host system that arbitrates and answers the bridge's bus requests.
module host_model (
  // Clock, reset and answer control.
  input  wire logic        clk, reset_n, bus_req, fail,
  input  wire logic [3:0]  dly,
  input  wire logic [31:0] bus_addr,
  // Answers.
  output logic             bus_grant, bus_done, bus_error,
  output logic [31:0]      bus_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  logic       seen_q;
  // Answer each request once after dly cycles; idle read data keeps changing.
  always_ff @(posedge clk) begin
    {bus_grant, bus_done, bus_error} <= 3'b000;
    bus_rdata <= ~bus_rdata;
    if (!reset_n || !bus_req) begin
      {cnt_q, seen_q} <= 5'h00;
      if (!reset_n) bus_rdata <= 32'h0;
    end else if (!seen_q && cnt_q == dly) begin
      bus_grant <= 1'b1;
      bus_done <= !fail;
      bus_error <= fail;
      bus_rdata <= ~bus_addr;
      seen_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench of the host bridge.
module testbench import bridge_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, dma_req, dma_last, bus_req, bus_write, bus_grant, bus_done, bus_error;
  logic dma_ack, dma_abort, desc_abort, txdata_err, close_err, soft_reset_bit, sts_clear;
  logic master_bus_error_irq, tgt_req, tgt_write, tgt_big_endian, tgt_taken, tgt_ready;
  logic reg_wr, irq_src, irq_disable, irq_status, host_irq_n, fail, flag_e;
  logic [31:0] dma_addr, dma_wdata, bus_addr, bus_wdata, bus_rdata, dma_rdata, tgt_wdata;
  logic [31:0] tgt_rdata, reg_wdata, reg_rdata, exp_w;
  logic [7:0]  tgt_addr, reg_addr;
  logic [4:0]  ev;
  logic [3:0]  dly, tgt_byte_en;
  req_kind_t   dma_kind;
  space_t      tgt_space, reg_space;
  int          seed = 36, n_errors = 0, check_count = 0, r;
  host_bridge u_host_bridge (.*);
  host_model u_host_model (.*);
  // Clock of 10 ns.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic end_sim();
    if (n_errors == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Expected answer bits: abort, close error, data error, descriptor abort, ack.
  function automatic logic [4:0] exp_ev(req_kind_t k, logic f, logic l, logic e);
    if (e) return 5'h10;
    if (!f) return 5'h01;
    if (k == REQ_DESC_READ) return 5'h02;
    if (k == REQ_TXDATA_RD) return l ? 5'h08 : 5'h04;
    return 5'h00;
  endfunction
  function automatic logic [31:0] swap(logic [31:0] w, logic s);
    return s ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction
  task automatic master(input req_kind_t k, input logic f);
    logic rd;
    int n;
    rd = (k == REQ_DESC_READ) || (k == REQ_TXDATA_RD);
    ev = 5'h00;
    n = 0;
    @(posedge clk);
    {dma_req, dma_kind, fail, dma_last} <= {1'b1, k, f, 1'($random(seed))};
    {dma_addr, dma_wdata} <= {32'($random(seed)), 32'($random(seed))};
    dly <= 4'($random(seed)) & 4'h7;
    #1;
    while (n < 30 && !(ev[4] || (dma_req === 1'b0 && bus_req === 1'b0))) begin
      @(posedge clk);
      if (bus_req === 1'b1) dma_req <= 1'b0;
      #1;
      ev = ev | {dma_abort, close_err, txdata_err, desc_abort, dma_ack};
      if (bus_req === 1'b1) chk(bus_addr === dma_addr && bus_write === !rd, "bus request");
      if (bus_req === 1'b1 && !rd) chk(bus_wdata === dma_wdata, "bus write data");
      if (dma_ack === 1'b1 && rd) chk(dma_rdata === ~dma_addr, "read data");
      n++;
    end
    chk(n < 30, "master timeout");
    @(posedge clk);
    dma_req <= 1'b0;
    @(posedge clk);
    chk(ev === exp_ev(k, f, dma_last, flag_e), "dma answer");
    flag_e = flag_e | (f & rd);
    chk(master_bus_error_irq === flag_e, "error status");
  endtask
  task automatic recover(input logic c);
    @(posedge clk);
    {sts_clear, soft_reset_bit} <= {c, !c};
    @(posedge clk);
    {sts_clear, soft_reset_bit} <= 2'b00;
    #1;
    chk(master_bus_error_irq === 1'b0, "status not cleared");
    flag_e = 1'b0;
  endtask
  task automatic target(input space_t s, input logic w, input logic [3:0] be, input logic big,
                        input logic h);
    logic [31:0] d;
    d = $random(seed);
    @(posedge clk);
    {tgt_req, tgt_space, tgt_write, tgt_byte_en, tgt_big_endian} <= {1'b1, s, w, be, big};
    {tgt_addr, tgt_wdata, reg_rdata} <= {8'($random(seed)), d, ~d};
    {irq_src, irq_disable} <= 2'($random(seed));
    @(posedge clk);
    tgt_req <= 1'b0;
    #1;
    exp_w = swap(w ? d : ~d, big && s == SPACE_MEM);
    if (w) chk(reg_wr === (be == FULL_BYTES) && (!reg_wr || reg_wdata === exp_w), "reg write");
    else chk(tgt_ready === 1'b1 && tgt_rdata === exp_w, "target read");
    chk(reg_addr === tgt_addr && reg_space === s, "reg address");
    @(posedge clk);
    tgt_taken <= !w && !h;
    @(posedge clk);
    tgt_taken <= 1'b0;
    #1;
    if (h) begin
      chk(tgt_ready === 1'b1, "flushed early");
      repeat (DISCARD_CLOCKS - 4) @(posedge clk);
      #1;
      chk(tgt_ready === 1'b1, "flushed before limit");
      repeat (8) @(posedge clk);
      #1;
    end
    chk(tgt_ready === 1'b0, "ready held");
    chk(host_irq_n === !(irq_src && !irq_disable) && irq_status === irq_src, "irq gate");
  endtask
  // Main sequence: corners, random traffic, register path, discard timer.
  initial begin
    {reset_n, dma_req, sts_clear, soft_reset_bit, tgt_req, tgt_taken, fail, flag_e} = '0;
    {irq_src, irq_disable, tgt_write, tgt_big_endian, dma_last, dly, tgt_byte_en} = '0;
    {dma_addr, dma_wdata, tgt_wdata, reg_rdata, tgt_addr} = '0;
    {dma_kind, tgt_space} = {REQ_DESC_READ, SPACE_CFG};
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 10; k++) begin
      master(req_kind_t'(k % 5), k > 4);
      master(REQ_RXDATA_WR, 1'b0);
      if (flag_e) recover(k[0]);
      if (flag_e) recover(1'b0);
    end
    repeat (60) begin
      r = $random(seed);
      master(req_kind_t'(3'(unsigned'(r) % 5)), r[7:5] == 3'h0);
      if (flag_e && r[9:8] == 2'h0) recover(1'b0);
    end
    for (int i = 0; i < 24; i++) begin
      target(space_t'(i % 3), 1'(i / 3 % 2), (i / 6 % 2) ? FULL_BYTES : 4'h3,
             1'(i / 12), 1'b0);
    end
    target(SPACE_MEM, 1'b0, FULL_BYTES, 1'b0, 1'b1);
    end_sim();
  end
  // Watchdog, set well beyond the discard wait plus all bus traffic.
  initial begin
    #600000;
    n_errors++;
    end_sim();
  end
endmodule
